/* File: rtl/piso_consts.vh */
// Constants shared by the parallel-in serial-out shift register design
`ifndef PISO_CONSTS_VH
`define PISO_CONSTS_VH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define PISO_STAGES 8
`define PISO_SYNC_DEPTH 2
`define PISO_FIFO_DEPTH 32
`define PISO_FIFO_PTR_W 5

// ----------------------------------------------------------------
// Reset values of the registered outputs
// ----------------------------------------------------------------
`define PISO_RST_SER_OUT 1'h0
`define PISO_RST_SER_OUT_N 1'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PISO_MCLK_PERIOD_NS 10
`define PISO_LINK_PERIOD_NS 160
// Edges after reset before synchronised pins and their delayed copies are trusted
`define PISO_WARM_DONE 2'h3
`define PISO_LINK_HALF_CYCLES ((`PISO_LINK_PERIOD_NS / 2) / `PISO_MCLK_PERIOD_NS)

`endif

/* File: rtl/piso_sync.v */
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module piso_sync
#(
  parameter WIDTH = 1
)
(
  input wire mclk,
  input wire resetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // First flop feeds only the second one
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] meta;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // piso_sync

`default_nettype wire

/* File: rtl/piso_fifo.v */
// Flip-flop FIFO with valid/ready on both sides and a registered read port
`timescale 1ns/100ps
`default_nettype none

module piso_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter PTR_W = 5
)
(
  input wire mclk,
  input wire resetn,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0] count;
  wire push;
  wire pop;
  wire [PTR_W:0] next_count;

  assign push = in_valid && in_ready;
  // Prefetch into the output register whenever it is free or being taken
  assign pop = (count != {(PTR_W+1){1'b0}}) && (!out_valid || out_ready);
  assign next_count = count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

  always @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
      if (pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      count <= next_count;
      in_ready <= (next_count != DEPTH[PTR_W:0]);
    end
  end

endmodule // piso_fifo

`default_nettype wire

/* File: rtl/piso_shift_register.v */
// Eight-stage parallel-in serial-out shift register with a snapshot tap FIFO
`timescale 1ns/100ps
`default_nettype none
`include "piso_consts.vh"

module piso_shift_register
#(
  parameter STAGES = `PISO_STAGES,
  parameter FIFO_DEPTH = `PISO_FIFO_DEPTH,
  parameter FIFO_PTR_W = `PISO_FIFO_PTR_W
)
(
  input wire mclk,
  input wire resetn,
  input wire shift_load_select,
  input wire shift_clk,
  input wire clock_block_input,
  input wire ser_in,
  input wire [STAGES-1:0] par_in,
  output reg ser_out,
  output reg ser_out_n,
  output wire tap_room,
  output wire tap_valid,
  input wire tap_ready,
  output wire [STAGES-1:0] tap_data,
  output reg tap_overflow
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  // Pins are asynchronous to mclk; load and shift act two cycles late
  wire [STAGES+3:0] pins_sync;
  wire sel_s;
  wire clk_s;
  wire blk_s;
  wire ser_s;
  wire [STAGES-1:0] par_s;

  piso_sync #(
    .WIDTH(STAGES + 4)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in({shift_load_select, shift_clk, clock_block_input, ser_in, par_in}),
    .sync_out(pins_sync)
  );

  assign sel_s = pins_sync[STAGES+3];
  assign clk_s = pins_sync[STAGES+2];
  assign blk_s = pins_sync[STAGES+1];
  assign ser_s = pins_sync[STAGES];
  assign par_s = pins_sync[STAGES-1:0];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  reg clk_d;
  reg blk_d;
  reg sel_d;
  reg [1:0] warm;
  wire live;
  wire clk_rise;
  wire blk_rise;
  wire shift_evt;
  wire load_now;
  wire load_release;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_d <= 1'b0;
      blk_d <= 1'b0;
      sel_d <= 1'b0;
      warm <= 2'h0;
    end
    else
    begin
      clk_d <= clk_s;
      blk_d <= blk_s;
      sel_d <= sel_s;
      if (warm != `PISO_WARM_DONE)
        warm <= warm + 2'h1;
    end
  end

  // The synchroniser resets to zero, which would read as a load and then
  // as a false release if select idles high; ignore pins until flushed
  assign live = (warm == `PISO_WARM_DONE);
  assign clk_rise = clk_s && !clk_d;
  assign blk_rise = blk_s && !blk_d;
  assign load_now = live && !sel_s;
  // A rise on either input counts only while the other sits low
  assign shift_evt = live && sel_s && ((clk_rise && !blk_s) || (blk_rise && !clk_s));
  assign load_release = live && sel_s && !sel_d;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Deliberately without reset: power-up content is unknown
  reg [STAGES-1:0] stage;

  always @(posedge mclk)
  begin
    if (load_now)
      stage <= par_s;
    else if (shift_evt)
      stage <= {stage[STAGES-2:0], ser_s};
    else
      stage <= stage;
  end

  // ----------------------------------------------------------------
  // Serial outputs
  // ----------------------------------------------------------------
  // While loading, the last stage already holds the last parallel bit
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ser_out <= `PISO_RST_SER_OUT;
      ser_out_n <= `PISO_RST_SER_OUT_N;
    end
    else
    begin
      ser_out <= stage[STAGES-1];
      ser_out_n <= ~stage[STAGES-1];
    end
  end

  // ----------------------------------------------------------------
  // Snapshot tap
  // ----------------------------------------------------------------
  // Each shift, and each end of a load, queues the new stage vector.
  // The pins cannot be stalled, so a full queue drops the word.
  reg push_pend;
  wire fifo_in_ready;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      push_pend <= 1'b0;
      tap_overflow <= 1'b0;
    end
    else
    begin
      push_pend <= shift_evt || load_release;
      if (push_pend && !fifo_in_ready)
        tap_overflow <= 1'b1;
    end
  end

  piso_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push_pend),
    .in_ready(fifo_in_ready),
    .in_data(stage),
    .out_valid(tap_valid),
    .out_ready(tap_ready),
    .out_data(tap_data)
  );

  assign tap_room = fifo_in_ready;

endmodule // piso_shift_register

`default_nettype wire

/* File: tb/piso_shift_register_properties.sv */
// Port checker for the shift register
`timescale 1ns/100ps
`default_nettype none
module piso_shift_register_properties
#(
  parameter STAGES = 8
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic shift_load_select,
  input wire logic shift_clk,
  input wire logic clock_block_input,
  input wire logic [STAGES-1:0] par_in,
  input wire logic ser_out,
  input wire logic ser_out_n,
  input wire logic tap_overflow
);
  // --
  // Pins reach the output 4 mclk later
  // --
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  load_value_a: assert property (
    (!shift_load_select && $stable(par_in))[*6] |-> ser_out == par_in[STAGES-1]) else $error("load");
  load_steady_a: assert property (
    (!shift_load_select && $stable(par_in))[*7] |-> $stable(ser_out)) else $error("load hold");
  compl_rise_a: assert property ($rose(ser_out) |-> !ser_out_n) else $error("rise");
  compl_fall_a: assert property ($fell(ser_out) |-> ser_out_n) else $error("fall");
  idle_hold_a: assert property (
    (shift_load_select && !shift_clk && !clock_block_input)[*7] |-> $stable(ser_out)) else $error("idle");
  clk_high_hold_a: assert property (
    (shift_load_select && shift_clk)[*7] |-> $stable(ser_out)) else $error("clk high");
  block_hold_a: assert property (
    (shift_load_select && clock_block_input)[*7] |-> $stable(ser_out)) else $error("block");
  overflow_sticky_a: assert property (tap_overflow |=> tap_overflow) else $error("ovf");
  shift_c: cover property ($rose(shift_clk) && !clock_block_input && shift_load_select);
  block_c: cover property ($rose(clock_block_input) && !shift_clk && shift_load_select);
  ovf_c: cover property ($rose(tap_overflow));
endmodule // piso_shift_register_properties
bind piso_shift_register piso_shift_register_properties #(.STAGES(STAGES)) u_props (.mclk,
  .resetn, .shift_load_select, .shift_clk, .clock_block_input, .par_in, .ser_out, .ser_out_n,
  .tap_overflow);
`default_nettype wire

/* File: tb/piso_ctrl_model.sv */
// Controller model that loads, clocks and samples
`timescale 1ns/100ps
`default_nettype none
module piso_ctrl_model
(
  input wire logic mclk,
  input wire logic ser_out,
  output logic shift_load_select = 1'h0,
  output logic shift_clk = 1'h0,
  output logic clock_block_input = 1'h0,
  output logic ser_in = 1'h0,
  output logic [7:0] par_in = 8'h00,
  output logic smp_valid = 1'h0,
  output logic smp_bit = 1'h0
);
  // --
  // Link tasks, one link period is 16 mclk
  // --
  task automatic load(input logic [7:0] p);
    par_in <= p;
    shift_load_select <= 1'h0;
    shift_clk <= 1'h1;
    repeat (8) @(posedge mclk);
    shift_clk <= 1'h0;
    shift_load_select <= 1'h1;
    repeat (4) @(posedge mclk);
    // Released lines float: show the inverse, not the last value
    par_in <= ~p;
    @(posedge mclk);
  endtask
  task automatic pulse(input logic d, input logic via);
    ser_in <= d;
    repeat (8) @(posedge mclk);
    smp_bit <= ser_out;
    smp_valid <= 1'h1;
    clock_block_input <= via;
    shift_clk <= !via;
    @(posedge mclk);
    smp_valid <= 1'h0;
    repeat (3) @(posedge mclk);
    ser_in <= ~d;
    shift_clk <= 1'h1;
    repeat (4) @(posedge mclk);
    shift_clk <= 1'h0;
    clock_block_input <= 1'h0;
    // Let an edge pass so a following call never reassigns these in one step
    @(posedge mclk);
  endtask
endmodule // piso_ctrl_model
`default_nettype wire

/* File: tb/piso_shift_register_tb.sv */
// Bench for the shift register
`timescale 1ns/100ps
`default_nettype none
module piso_shift_register_tb;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic tap_ready = 1'h0;
  logic hold = 1'h0;
  logic ovf_exp = 1'h0;
  logic [7:0] st = 8'h00;
  logic exp_q[$];
  logic [7:0] tq[$];
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  wire shift_load_select, shift_clk, clock_block_input, ser_in, ser_out, ser_out_n;
  wire tap_room, tap_valid, tap_overflow, smp_valid, smp_bit;
  wire [7:0] par_in, tap_data;
  always #5 mclk = ~mclk;
  piso_shift_register u_piso_shift_register (.mclk, .resetn, .shift_load_select, .shift_clk,
    .clock_block_input, .ser_in, .par_in, .ser_out, .ser_out_n, .tap_room, .tap_valid,
    .tap_ready, .tap_data, .tap_overflow);
  piso_ctrl_model u_piso_ctrl_model (.mclk, .ser_out, .shift_load_select, .shift_clk,
    .clock_block_input, .ser_in, .par_in, .smp_valid, .smp_bit);
  // --
  // Tasks
  // --
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Tap holds 33 words; later snapshots are dropped
  task automatic push_tap(input logic [7:0] w);
    if (tq.size() < 33)
      tq.push_back(w);
    else
      ovf_exp = 1'h1;
  endtask
  task automatic ld(input logic [7:0] p);
    st = p;
    push_tap(p);
    u_piso_ctrl_model.load(p);
  endtask
  task automatic sh(input logic d, input logic via);
    exp_q.push_back(st[7]);
    st = {st[6:0], d};
    push_tap(st);
    u_piso_ctrl_model.pulse(d, via);
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    tap_ready <= !hold && ($urandom % 4 != 0);
    if (smp_valid)
      check({7'h0, smp_bit}, {7'h0, exp_q.pop_front()});
    if (tap_valid && tap_ready)
    begin
      if (tq.size() == 0)
      begin
        error_cnt++;
        $display("unexpected %0t extra tap word %h", $time, tap_data);
      end
      else
        check(tap_data, tq.pop_front());
    end
    if (cyc == 3000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(1497));
    repeat (10) @(posedge mclk);
    check({3'h0, ser_out, ser_out_n, tap_valid, tap_overflow, tap_room}, 8'h09);
    resetn <= 1'h1;
    ld(8'($urandom));
    for (int i = 0; i < 10; i++)
      sh(1'($urandom), 1'(i));
    $display("test shift done");
    ld(8'($urandom));
    ld(8'($urandom));
    for (int i = 0; i < 9; i++)
      sh(1'($urandom), 1'($urandom));
    $display("test reload done");
    hold <= 1'h1;
    for (int i = 0; i < 40; i++)
      sh(1'($urandom), 1'($urandom));
    check({6'h0, tap_overflow, tap_room}, {6'h0, ovf_exp, 1'h0});
    hold <= 1'h0;
    for (int i = 0; i < 300 && tq.size() > 0; i++)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
    check({6'h0, tap_valid, tap_room}, 8'h01);
    $display("test fill done");
    summarize();
  end
endmodule // piso_shift_register_tb
`default_nettype wire
